// ### mmeb_defines.svh
// Offsets, field positions, reset values and fixed figures of the exec block
`ifndef MMEB_DEFINES_SVH
`define MMEB_DEFINES_SVH
`define MMEB_OFF_CTRL 12'h000
`define MMEB_OFF_STAT 12'h004
`define MMEB_CTRL_EN 0
`define MMEB_STAT_V 0
`define MMEB_STAT_C 1
`define MMEB_STAT_Z 2
`define MMEB_STAT_N 3
`define MMEB_STAT_T 4
`define MMEB_STAT_FAULT 5
`define MMEB_CTRL_RST 1'b1
`define MMEB_T_RST 1'b1
`define MMEB_FLAGS_RST 4'h0
`define MMEB_PC_AHEAD 32'h0000_0004
`define MMEB_LEN_LDIR 32'h0000_0004
`define MMEB_LEN_LIND 32'h0000_0002
`define MMEB_LINK_REG 4'he
`define MMEB_PC_REG 4'hf
`define MMEB_OFS_B 12
`define MMEB_OFS_BC 9
`define MMEB_OFS_LINK 25
`define MMEB_SIGN_W 31
`define MMEB_SIGN_H 15
`define MMEB_SIGN_B 7
`endif

// ### mmeb_pkg.sv
// Types shared by the exec block and its users
package mmeb_pkg;
	typedef enum logic [4:0] {
		OP_NONE = 5'h00, OP_COPY = 5'h01, OP_COPY_FLAGS = 5'h02,
		OP_COPY_IMM = 5'h03, OP_INV_COPY = 5'h04, OP_MUL = 5'h05,
		OP_REV = 5'h06, OP_HALF_REV = 5'h07, OP_SHALF_REV = 5'h08,
		OP_SEXT_BYTE = 5'h09, OP_SEXT_HALF = 5'h0a, OP_ZEXT_BYTE = 5'h0b,
		OP_ZEXT_HALF = 5'h0c, OP_TEST = 5'h0d, OP_BR = 5'h0e,
		OP_BR_COND = 5'h0f, OP_BR_LINK = 5'h10, OP_BR_IND = 5'h11,
		OP_BR_LIND = 5'h12
	} mmeb_op_t;
	typedef enum logic [3:0] {
		CC_EQ = 4'h0, CC_NE = 4'h1, CC_CS = 4'h2, CC_CC = 4'h3,
		CC_MI = 4'h4, CC_PL = 4'h5, CC_VS = 4'h6, CC_VC = 4'h7,
		CC_HI = 4'h8, CC_LS = 4'h9, CC_GE = 4'ha, CC_LT = 4'hb,
		CC_GT = 4'hc, CC_LE = 4'hd, CC_AL = 4'he
	} mmeb_cond_t;
	typedef struct packed {
		mmeb_op_t op;
		logic [3:0] rd;
		logic [31:0] opA;
		logic [31:0] opB;
		logic [7:0] imm;
		logic [24:0] ofs;
		mmeb_cond_t cond;
		logic [31:0] pc;
	} mmeb_issue_t;
	typedef struct packed {
		logic we;
		logic [3:0] rd;
		logic [31:0] data;
	} mmeb_wb_t;
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} mmeb_flags_t;
endpackage

// ### mmeb_exec.sv
// Move, multiply, extend and branch execution stage with APB control
`timescale 1ns/1ps
`include "mmeb_defines.svh"
module mmeb_exec #(
	parameter int DATA_W = 32
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic issueValid,
	input wire mmeb_pkg::mmeb_issue_t issue,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output mmeb_pkg::mmeb_wb_t wb,
	output mmeb_pkg::mmeb_flags_t flags,
	output logic tBit,
	output logic redirValid,
	output logic [31:0] redirPc,
	output logic flush,
	output logic fault
);

	// Only the documented word width is served
	if (DATA_W != 32) begin : g_chk
		$error("mmeb_exec supports DATA_W of 32 only");
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic ctrlEn_q;
	logic faultSticky_q;
	logic ready_q;
	logic go;
	logic apbAcc;
	logic stickyClr;
	logic [31:0] res;
	logic [63:0] prod;
	logic wbWe;
	logic [3:0] wbRd;
	logic setNZ;
	logic brTake;
	logic [31:0] brPc;
	logic tLoad;
	logic faultD;

	assign go = issueValid & ctrlEn_q;
	assign apbAcc = psel & penable & ready_q;

	////////////////////////////////////////////////////////////////////////
	// Datapath

	function automatic logic condOk(input mmeb_pkg::mmeb_cond_t c,
		input mmeb_pkg::mmeb_flags_t f);
		unique case (c)
			mmeb_pkg::CC_EQ: condOk = f.z;
			mmeb_pkg::CC_NE: condOk = ~f.z;
			mmeb_pkg::CC_CS: condOk = f.c;
			mmeb_pkg::CC_CC: condOk = ~f.c;
			mmeb_pkg::CC_MI: condOk = f.n;
			mmeb_pkg::CC_PL: condOk = ~f.n;
			mmeb_pkg::CC_VS: condOk = f.v;
			mmeb_pkg::CC_VC: condOk = ~f.v;
			mmeb_pkg::CC_HI: condOk = f.c & ~f.z;
			mmeb_pkg::CC_LS: condOk = ~f.c | f.z;
			mmeb_pkg::CC_GE: condOk = f.n == f.v;
			mmeb_pkg::CC_LT: condOk = f.n != f.v;
			mmeb_pkg::CC_GT: condOk = ~f.z & (f.n == f.v);
			mmeb_pkg::CC_LE: condOk = f.z | (f.n != f.v);
			mmeb_pkg::CC_AL: condOk = 1'b1;
			default: condOk = 1'b0;
		endcase
	endfunction

	// Low product word is sign-independent, so one unsigned path suffices
	assign prod = 64'(issue.opA) * 64'(issue.opB);

	// Result, writeback, flag and branch decisions for the issued operation
	always_comb begin
		res = issue.opA;
		wbWe = 1'b0;
		wbRd = issue.rd;
		setNZ = 1'b0;
		brTake = 1'b0;
		brPc = '0;
		tLoad = 1'b0;
		faultD = 1'b0;
		unique case (issue.op)
			mmeb_pkg::OP_NONE: begin
				res = issue.opA;
			end
			mmeb_pkg::OP_COPY: begin
				if (issue.rd == `MMEB_PC_REG) begin
					brTake = 1'b1;
					brPc = {issue.opA[31:1], 1'b0};
				end else begin
					wbWe = 1'b1;
				end
			end
			mmeb_pkg::OP_COPY_FLAGS: begin
				wbWe = 1'b1;
				setNZ = 1'b1;
			end
			mmeb_pkg::OP_COPY_IMM: begin
				res = {24'h000000, issue.imm};
				wbWe = 1'b1;
				setNZ = 1'b1;
			end
			mmeb_pkg::OP_INV_COPY: begin
				res = ~issue.opA;
				wbWe = 1'b1;
				setNZ = 1'b1;
			end
			mmeb_pkg::OP_MUL: begin
				res = prod[31:0];
				wbWe = 1'b1;
				setNZ = 1'b1;
			end
			mmeb_pkg::OP_REV: begin
				res = {issue.opA[7:0], issue.opA[15:8],
					issue.opA[23:16], issue.opA[31:24]};
				wbWe = 1'b1;
			end
			mmeb_pkg::OP_HALF_REV: begin
				res = {issue.opA[23:16], issue.opA[31:24],
					issue.opA[7:0], issue.opA[15:8]};
				wbWe = 1'b1;
			end
			mmeb_pkg::OP_SHALF_REV: begin
				res = {{16{issue.opA[`MMEB_SIGN_B]}},
					issue.opA[7:0], issue.opA[15:8]};
				wbWe = 1'b1;
			end
			mmeb_pkg::OP_SEXT_BYTE: begin
				res = {{24{issue.opA[`MMEB_SIGN_B]}}, issue.opA[7:0]};
				wbWe = 1'b1;
			end
			mmeb_pkg::OP_ZEXT_BYTE: begin
				res = {24'h000000, issue.opA[7:0]};
				wbWe = 1'b1;
			end
			mmeb_pkg::OP_SEXT_HALF: begin
				res = {{16{issue.opA[`MMEB_SIGN_H]}}, issue.opA[15:0]};
				wbWe = 1'b1;
			end
			mmeb_pkg::OP_ZEXT_HALF: begin
				res = {16'h0000, issue.opA[15:0]};
				wbWe = 1'b1;
			end
			mmeb_pkg::OP_TEST: begin
				res = issue.opA & issue.opB;
				setNZ = 1'b1;
			end
			mmeb_pkg::OP_BR: begin
				brTake = 1'b1;
				brPc = issue.pc + `MMEB_PC_AHEAD
					+ {{(32 - `MMEB_OFS_B){issue.ofs[`MMEB_OFS_B - 1]}},
					issue.ofs[`MMEB_OFS_B - 1:0]};
			end
			mmeb_pkg::OP_BR_COND: begin
				brTake = condOk(issue.cond, flags);
				brPc = issue.pc + `MMEB_PC_AHEAD
					+ {{(32 - `MMEB_OFS_BC){issue.ofs[`MMEB_OFS_BC - 1]}},
					issue.ofs[`MMEB_OFS_BC - 1:0]};
			end
			mmeb_pkg::OP_BR_LINK: begin
				brTake = 1'b1;
				brPc = issue.pc + `MMEB_PC_AHEAD
					+ {{(32 - `MMEB_OFS_LINK){issue.ofs[`MMEB_OFS_LINK - 1]}},
					issue.ofs[`MMEB_OFS_LINK - 1:0]};
				wbWe = 1'b1;
				wbRd = `MMEB_LINK_REG;
				res = (issue.pc + `MMEB_LEN_LDIR) | 32'h0000_0001;
			end
			mmeb_pkg::OP_BR_IND, mmeb_pkg::OP_BR_LIND: begin
				tLoad = 1'b1;
				faultD = ~issue.opA[0];
				brTake = issue.opA[0];
				brPc = {issue.opA[31:1], 1'b0};
				if (issue.op == mmeb_pkg::OP_BR_LIND) begin
					wbWe = 1'b1;
					wbRd = `MMEB_LINK_REG;
					res = (issue.pc + `MMEB_LEN_LIND) | 32'h0000_0001;
				end
			end
			default: begin
				res = issue.opA;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Writeback

	// Result port toward the register file
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb <= '0;
		end else begin
			wb.we <= go & wbWe;
			wb.rd <= wbRd;
			wb.data <= res;
		end
	end

	// N and Z follow the result; C and V are never touched here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags <= `MMEB_FLAGS_RST;
		end else if (go && setNZ) begin
			flags.n <= res[31];
			flags.z <= (res == 32'h0000_0000);
		end
	end

	// Execution-state bit, loaded only by indirect branches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tBit <= `MMEB_T_RST;
		end else if (go && tLoad) begin
			tBit <= issue.opA[0];
		end
	end

	// Redirect, flush and fault pulses
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			redirValid <= 1'b0;
			redirPc <= '0;
			flush <= 1'b0;
			fault <= 1'b0;
		end else begin
			redirValid <= go & brTake;
			flush <= go & brTake;
			redirPc <= brPc;
			fault <= go & faultD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave

	assign stickyClr = apbAcc & pwrite & (paddr == `MMEB_OFF_STAT)
		& pwdata[`MMEB_STAT_FAULT];

	// No wait state: ready rises in the cycle after setup
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ready_q <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			ready_q <= psel & ~ready_q;
			pslverr <= psel & ~ready_q & (paddr != `MMEB_OFF_CTRL)
				& (paddr != `MMEB_OFF_STAT);
			prdata <= '0;
			if (psel && !ready_q && !pwrite) begin
				if (paddr == `MMEB_OFF_CTRL) begin
					prdata[`MMEB_CTRL_EN] <= ctrlEn_q;
				end else if (paddr == `MMEB_OFF_STAT) begin
					prdata[`MMEB_STAT_N] <= flags.n;
					prdata[`MMEB_STAT_Z] <= flags.z;
					prdata[`MMEB_STAT_C] <= flags.c;
					prdata[`MMEB_STAT_V] <= flags.v;
					prdata[`MMEB_STAT_T] <= tBit;
					prdata[`MMEB_STAT_FAULT] <= faultSticky_q;
				end
			end
		end
	end

	assign pready = ready_q;

	// Execute enable written by software
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlEn_q <= `MMEB_CTRL_RST;
		end else if (apbAcc && pwrite && paddr == `MMEB_OFF_CTRL) begin
			ctrlEn_q <= pwdata[`MMEB_CTRL_EN];
		end
	end

	// Sticky fault record; a new fault beats a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			faultSticky_q <= 1'b0;
		end else begin
			faultSticky_q <= (faultSticky_q & ~stickyClr) | (go & faultD);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_imm_zext: assert property (go && issue.op == mmeb_pkg::OP_COPY_IMM
		|=> wb.we && wb.data == {24'h000000, $past(issue.imm)})
		else $error("immediate copy not zero-extended");
	chk_copy_same: assert property (go && issue.op == mmeb_pkg::OP_COPY_FLAGS
		|=> wb.data == $past(issue.opA) && flags.n == wb.data[31])
		else $error("register copy altered value");
	chk_cv_kept: assert property ($stable(flags.c) && $stable(flags.v))
		else $error("carry or overflow changed");
	chk_inv_copy: assert property (go && issue.op == mmeb_pkg::OP_INV_COPY
		|=> wb.data == ~$past(issue.opA))
		else $error("inverted copy wrong");
	chk_pc_copy: assert property (go && issue.op == mmeb_pkg::OP_COPY
		&& issue.rd == `MMEB_PC_REG |=> redirValid && !redirPc[0]
		&& !wb.we && $stable(tBit))
		else $error("copy to pc misbehaved");
	chk_mul_low: assert property (go && issue.op == mmeb_pkg::OP_MUL
		|=> wb.data == $past(issue.opA) * $past(issue.opB))
		else $error("multiply low word wrong");
	chk_half_rev: assert property (go && issue.op == mmeb_pkg::OP_HALF_REV
		|=> wb.data[15:0] == {$past(issue.opA[7:0]), $past(issue.opA[15:8])}
		&& $stable(flags))
		else $error("halfword reverse wrong");
	chk_ext_flags: assert property (go && issue.op inside {mmeb_pkg::OP_SEXT_BYTE,
		mmeb_pkg::OP_SEXT_HALF, mmeb_pkg::OP_ZEXT_BYTE, mmeb_pkg::OP_ZEXT_HALF}
		|=> $stable(flags))
		else $error("extension changed flags");
	chk_test_nowb: assert property (go && issue.op == mmeb_pkg::OP_TEST
		|=> !wb.we && flags.z == (($past(issue.opA) & $past(issue.opB)) == 32'h0000_0000))
		else $error("bit test wrote register or bad Z");
	chk_link_bit: assert property (go && issue.op inside {mmeb_pkg::OP_BR_LINK,
		mmeb_pkg::OP_BR_LIND} |=> wb.we && wb.rd == `MMEB_LINK_REG && wb.data[0])
		else $error("link value bit 0 clear");
	chk_ind_fault: assert property (go && issue.op inside {mmeb_pkg::OP_BR_IND,
		mmeb_pkg::OP_BR_LIND} && !issue.opA[0] |=> fault && !redirValid)
		else $error("indirect branch did not fault");
	chk_br_flags: assert property (go && issue.op inside {mmeb_pkg::OP_BR,
		mmeb_pkg::OP_BR_COND, mmeb_pkg::OP_BR_LINK} |=> $stable(flags))
		else $error("branch changed flags");
	chk_flush_pair: assert property (redirValid == flush)
		else $error("redirect without flush");

	cov_link_branch: cover property (go && issue.op == mmeb_pkg::OP_BR_LINK ##1 redirValid);
	cov_fault: cover property (fault);
	cov_cond_skip: cover property (go && issue.op == mmeb_pkg::OP_BR_COND ##1 !redirValid);
	cov_mul: cover property (go && issue.op == mmeb_pkg::OP_MUL);

endmodule

// ### mmeb_exec_tb.sv
// Self-checking testbench for the move, multiply, extend and branch stage
`timescale 1ns/1ps
`include "mmeb_defines.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errorCnt++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module mmeb_exec_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic issueValid = 1'b0;
	mmeb_pkg::mmeb_issue_t issue = '0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, redirPc, rq;
	logic pready, pslverr, tBit, redirValid, flush, fault, re;
	mmeb_pkg::mmeb_wb_t wb;
	mmeb_pkg::mmeb_flags_t flags;
	int errorCnt = 0;
	int nTests = 0;
	int cycCnt = 0;
	// Expected taken pattern per condition code with only Z set
	logic [14:0] condTaken = 15'h66a9;
	mmeb_pkg::mmeb_op_t extOp [7] = '{mmeb_pkg::OP_REV, mmeb_pkg::OP_HALF_REV,
		mmeb_pkg::OP_SHALF_REV, mmeb_pkg::OP_SEXT_BYTE, mmeb_pkg::OP_SEXT_HALF,
		mmeb_pkg::OP_ZEXT_BYTE, mmeb_pkg::OP_ZEXT_HALF};
	logic [31:0] extIn [7] = '{32'h11223344, 32'h11223344, 32'h123480ff,
		32'h12345680, 32'h12348000, 32'h123456f0, 32'h1234fff0};
	logic [31:0] extOut [7] = '{32'h44332211, 32'h22114433, 32'hffffff80,
		32'hffffff80, 32'hffff8000, 32'h000000f0, 32'h0000fff0};

	mmeb_exec dut (.clk(clk), .arst_n(arst_n), .issueValid(issueValid), .issue(issue),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .wb(wb), .flags(flags),
		.tBit(tBit), .redirValid(redirValid), .redirPc(redirPc), .flush(flush),
		.fault(fault));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		forever #4 clk = ~clk;
	end

	always @(posedge clk) begin
		cycCnt++;
		if (cycCnt == 4000) begin
			errorCnt++;
			closeOut();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task closeOut();
		$display("comparisons %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task endTest(input string nm);
		$display("test %s done", nm);
	endtask

	// One APB transfer: setup, then access held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Ends when pready is seen high; the bench timeout ends it otherwise
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One issued operation; outputs are looked at just after the taking edge
	task doOp(input mmeb_pkg::mmeb_op_t o, input logic [3:0] r, input logic [31:0] a,
		input logic [31:0] b = 32'h0, input logic [7:0] im = 8'h00,
		input logic [24:0] f = 25'h0, input logic [31:0] p = 32'h0,
		input mmeb_pkg::mmeb_cond_t c = mmeb_pkg::CC_AL);
		@(posedge clk);
		issueValid <= 1'b1;
		issue <= '{op: o, rd: r, opA: a, opB: b, imm: im, ofs: f, cond: c, pc: p};
		@(posedge clk);
		issueValid <= 1'b0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		`CHK("flags rst", 4'h0, flags)
		`CHK("tbit rst", 1'b1, tBit)
		`CHK("pulses rst", 4'h0, {wb.we, redirValid, flush, fault})
		apb(1'b0, `MMEB_OFF_CTRL, 32'h0, rq, re);
		`CHK("ctrl rst", 33'h000000001, {re, rq})
		apb(1'b0, `MMEB_OFF_STAT, 32'h0, rq, re);
		`CHK("stat rst", 33'h000000010, {re, rq})
		apb(1'b0, 12'h008, 32'h0, rq, re);
		`CHK("unmapped", 33'h100000000, {re, rq})
		endTest("reset");
		doOp(mmeb_pkg::OP_COPY_IMM, 4'h3, 32'h0, 32'h0, 8'hff);
		`CHK("imm wb", {1'b1, 4'h3, 32'h000000ff}, wb)
		`CHK("imm flg", 4'h0, flags)
		doOp(mmeb_pkg::OP_COPY_IMM, 4'h1, 32'h0, 32'h0, 8'h00);
		`CHK("imm0 flg", 4'h4, flags)
		doOp(mmeb_pkg::OP_COPY, 4'h2, 32'h80000001);
		`CHK("copy wb", {1'b1, 4'h2, 32'h80000001}, wb)
		`CHK("copy flg", 4'h4, flags)
		doOp(mmeb_pkg::OP_COPY_FLAGS, 4'h2, 32'h80000001);
		`CHK("copys flg", 4'h8, flags)
		doOp(mmeb_pkg::OP_INV_COPY, 4'h4, 32'h7fffffff);
		`CHK("inv wb", {1'b1, 4'h4, 32'h80000000}, wb)
		doOp(mmeb_pkg::OP_INV_COPY, 4'h4, 32'hffffffff);
		`CHK("inv0", {1'b1, 4'h4, 32'h0, 4'h4}, {wb, flags})
		endTest("copy");
		doOp(mmeb_pkg::OP_MUL, 4'h5, 32'hffffffff, 32'h3);
		`CHK("mul", {1'b1, 4'h5, 32'hfffffffd, 4'h8}, {wb, flags})
		doOp(mmeb_pkg::OP_MUL, 4'h5, 32'h00010000, 32'h00010000);
		`CHK("mul hi", {1'b1, 4'h5, 32'h0, 4'h4}, {wb, flags})
		// Flags stand at Z only through every reversal and extension
		for (int i = 0; i < 7; i++) begin
			doOp(extOp[i], 4'h6, extIn[i]);
			`CHK("ext", {1'b1, 4'h6, extOut[i], 4'h4}, {wb, flags})
		end
		endTest("mul ext");
		doOp(mmeb_pkg::OP_TEST, 4'h7, 32'h80000000, 32'hffffffff);
		`CHK("test", 5'h08, {wb.we, flags})
		doOp(mmeb_pkg::OP_TEST, 4'h7, 32'h000000f0, 32'h0000000f);
		`CHK("test0", 5'h04, {wb.we, flags})
		// Every condition code against Z-only flags, offset -256
		for (int k = 0; k < 15; k++) begin
			doOp(mmeb_pkg::OP_BR_COND, 4'h0, 32'h0, 32'h0, 8'h00, 25'h0000100, 32'h200,
				mmeb_pkg::mmeb_cond_t'(k));
			`CHK("cond br", {{2{condTaken[k]}}, 1'b0, 4'h4}, {redirValid, flush, fault, flags})
			if (condTaken[k]) begin
				`CHK("cond pc", 32'h00000104, redirPc)
			end
		end
		doOp(mmeb_pkg::OP_BR_COND, 4'h0, 32'h0, 32'h0, 8'h00, 25'h1fff0fe, 32'h200);
		`CHK("cond max", {2'b11, 32'h00000302}, {redirValid, flush, redirPc})
		doOp(mmeb_pkg::OP_BR, 4'h0, 32'h0, 32'h0, 8'h00, 25'h1fff800, 32'h100,
			mmeb_pkg::CC_NE);
		`CHK("b", {2'b11, 32'hfffff904, 4'h4}, {redirValid, flush, redirPc, flags})
		doOp(mmeb_pkg::OP_BR_LINK, 4'he, 32'h0, 32'h0, 8'h00, 25'h1000000, 32'h1000);
		`CHK("link br", {2'b11, 32'hff001004}, {redirValid, flush, redirPc})
		`CHK("link br ret", {1'b1, 4'he, 32'h00001005}, wb)
		endTest("direct branch");
		doOp(mmeb_pkg::OP_BR_IND, 4'h0, 32'h00000301);
		`CHK("ind", {3'b110, 32'h00000300, 1'b1}, {redirValid, flush, fault, redirPc, tBit})
		doOp(mmeb_pkg::OP_BR_IND, 4'h0, 32'h00000300);
		`CHK("ind flt", {4'b0010, 1'b0}, {redirValid, flush, fault, wb.we, tBit})
		apb(1'b0, `MMEB_OFF_STAT, 32'h0, rq, re);
		`CHK("stat flt", 33'h000000024, {re, rq})
		apb(1'b1, `MMEB_OFF_STAT, 32'h20, rq, re);
		apb(1'b0, `MMEB_OFF_STAT, 32'h0, rq, re);
		`CHK("stat clr", 32'h00000004, rq)
		doOp(mmeb_pkg::OP_BR_LIND, 4'he, 32'h00000401, 32'h0, 8'h00, 25'h0, 32'h50);
		`CHK("lind", {2'b11, 32'h00000400, 1'b1}, {redirValid, flush, redirPc, tBit})
		`CHK("lind ret", {1'b1, 4'he, 32'h00000053}, wb)
		doOp(mmeb_pkg::OP_BR_LIND, 4'he, 32'h00000400, 32'h0, 8'h00, 25'h0, 32'h50);
		`CHK("lind flt", {3'b001, 1'b0}, {redirValid, flush, fault, tBit})
		doOp(mmeb_pkg::OP_COPY, 4'hf, 32'h00001235);
		`CHK("pc copy", {3'b110, 32'h00001234, 1'b0}, {redirValid, flush, wb.we, redirPc, tBit})
		endTest("indirect branch");
		apb(1'b1, `MMEB_OFF_CTRL, 32'h0, rq, re);
		doOp(mmeb_pkg::OP_COPY_IMM, 4'h3, 32'h0, 32'h0, 8'h05);
		`CHK("disabled", 1'b0, wb.we)
		apb(1'b1, `MMEB_OFF_CTRL, 32'h1, rq, re);
		apb(1'b0, `MMEB_OFF_CTRL, 32'h0, rq, re);
		`CHK("ctrl rd", 33'h000000001, {re, rq})
		doOp(mmeb_pkg::OP_COPY_IMM, 4'h3, 32'h0, 32'h0, 8'h05);
		`CHK("enabled", {1'b1, 4'h3, 32'h00000005}, wb)
		endTest("control");
		closeOut();
	end
endmodule
